/* File: hw/fsp_array_mem.sv */
`timescale 1ns/1ps
module fsp_array_mem #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(2**AW)-1];

  // Read data is registered, so a write shows on rdata one edge later.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // fsp_array_mem

/* File: hw/fsp_flash_access.sv */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module fsp_flash_access #(
  parameter int unsigned ARRAY_BYTES  = 8192,
  parameter logic        LOCK_DEFAULT = 1'b0
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire fsp_pkg::fsp_wb_req_type wbReq,
  output fsp_pkg::fsp_wb_rsp_type      wbRsp,
  input  wire logic                   linkClk,
  input  wire logic                   linkDataIn,
  output logic                        linkDataOut,
  output logic                        linkDataOe,
  input  wire logic                   toolAttached,
  input  wire logic                   socketMode,
  input  wire logic                   appDataOut,
  input  wire logic                   appDataOe,
  output logic                        appDataIn,
  output fsp_pkg::fsp_mode_type        progMode,
  output logic                        readoutLocked
);
  import fsp_pkg::*;

  localparam int unsigned   AW            = $clog2(ARRAY_BYTES);
  localparam logic [AW-1:0] LAST_IDX      = AW'(ARRAY_BYTES - 1);
  localparam logic [AW-1:0] SEC_MASK      = AW'(SECTOR_BYTES - 1);
  localparam logic [AW-1:0] SEC2_LAST_IDX = SECTOR2_LAST[AW-1:0];

  typedef struct packed {
    logic          ack;
    logic [7:0]    rdat;
    logic [7:0]    fpc;
    logic [15:0]   addr;
    logic [7:0]    pdata;
    fsp_state_type state;
    logic [AW-1:0] cur;
    logic [AW-1:0] first;
    logic [AW-1:0] last;
    logic          unlockPend;
    logic          lock;
    logic          error;
    fsp_mode_type  mode;
    logic          in_circuit_link;
    logic          att1;
    logic          att2;
    logic          sock1;
    logic          sock2;
    logic          pin1;
    logic          pin2;
    logic          tgl1;
    logic          tgl2;
    logic          tgl3;
  } fsp_core_type;

  localparam fsp_core_type CORE_RESET = '{
    state:   ST_IDLE,
    mode:    MODE_APP,
    lock:    LOCK_DEFAULT,
    default: '0
  };

  localparam fsp_link_type LINK_IDLE = '{default: '0};

  fsp_core_type  coreReg;
  fsp_core_type  coreNext;
  fsp_link_type  linkReg;
  fsp_link_type  linkNext;
  logic [AW-1:0] memAddr;
  logic          memWe;
  logic [7:0]    memWdata;
  logic [7:0]    memRdata;
  logic          busReq;
  logic          busWr;
  logic [7:0]    busIdx;
  logic [7:0]    wdat;
  fsp_cmd_type   op;
  logic [AW-1:0] addrIdx;
  logic          inArray;
  logic          hitS0;
  logic          hitS1;
  logic          cmdWr;
  logic          optWr;
  logic          optClear;
  logic          optSet;
  logic          refuse;
  logic          enterEdge;

  assign busReq  = wbReq.cyc & wbReq.stb & ~coreReg.ack;
  assign busWr   = busReq & wbReq.we & wbReq.sel[0];
  assign busIdx  = wbReq.adr[WB_ADR_W-1:2];
  assign wdat    = wbReq.dat[7:0];
  assign op      = fsp_cmd_type'(wdat[1:0]);
  assign addrIdx = coreReg.addr[AW-1:0];

  // The array sits at the top of the space; smaller arrays lose the lower sectors.
  assign inArray = &coreReg.addr[15:AW];
  assign hitS0   = coreReg.addr[15:SECTOR_AW] == SECTOR0_TOP;
  assign hitS1   = coreReg.addr[15:SECTOR_AW] == SECTOR1_TOP;

  assign cmdWr    = busWr && (busIdx == IDX_CMD);
  assign optWr    = busWr && (busIdx == IDX_OPTION);
  assign optClear = optWr && !wdat[OPT_LOCK_BIT] && coreReg.lock;
  assign optSet   = optWr && wdat[OPT_LOCK_BIT] && !coreReg.lock;
  assign enterEdge = coreReg.tgl2 ^ coreReg.tgl3;

  // Socket and in-circuit modes may touch sector 0 and erase all.
  assign refuse = !coreReg.fpc[FPC_ARM_BIT]
                  || coreReg.lock
                  || (op == CMD_NONE)
                  || (!inArray && (op != CMD_ERASE_ALL))
                  || ((coreReg.mode == MODE_APP)
                      && (hitS0 || (op == CMD_ERASE_ALL)));

  // Programming can only clear bits, as on a real cell, so the old byte is merged.
  assign memWe    = (coreReg.state == ST_PROGRAM) || (coreReg.state == ST_ERASE);
  assign memAddr  = (coreReg.state == ST_IDLE) ? addrIdx : coreReg.cur;
  assign memWdata = (coreReg.state == ST_ERASE) ? ERASED_BYTE
                                                : (coreReg.pdata & memRdata);

  always_comb begin
    coreNext       = coreReg;
    coreNext.att1  = toolAttached;
    coreNext.att2  = coreReg.att1;
    coreNext.sock1 = socketMode;
    coreNext.sock2 = coreReg.sock1;
    coreNext.pin1  = linkDataIn;
    coreNext.pin2  = coreReg.pin1;
    coreNext.tgl1  = linkReg.enterTgl;
    coreNext.tgl2  = coreReg.tgl1;
    coreNext.tgl3  = coreReg.tgl2;
    coreNext.ack   = busReq;

    if (coreReg.sock2) begin
      coreNext.mode = MODE_SOCKET;
    end else if (!coreReg.att2) begin
      coreNext.mode = MODE_APP;
    end else if (enterEdge) begin
      coreNext.mode = MODE_ICC;
    end else if (coreReg.mode == MODE_SOCKET) begin
      coreNext.mode = MODE_APP;
    end
    coreNext.in_circuit_link = (coreNext.mode == MODE_ICC);

    case (busIdx)
      IDX_FPC:     coreNext.rdat = coreReg.fpc;
      IDX_ADDR_LO: coreNext.rdat = coreReg.addr[7:0];
      IDX_ADDR_HI: coreNext.rdat = coreReg.addr[15:8];
      IDX_DATA:    coreNext.rdat = (coreReg.lock && (coreReg.mode != MODE_APP))
                                   ? 8'h00 : memRdata;
      IDX_CMD:     coreNext.rdat = {6'h00, coreReg.state};
      IDX_STATUS:  coreNext.rdat = {2'h0, coreReg.att2, coreReg.mode, coreReg.lock,
                                    coreReg.error, coreReg.state != ST_IDLE};
      IDX_OPTION:  coreNext.rdat = {7'h00, coreReg.lock};
      default:     coreNext.rdat = 8'h00;
    endcase

    if (busWr) begin
      case (busIdx)
        IDX_FPC:     coreNext.fpc = wdat;
        IDX_ADDR_LO: coreNext.addr[7:0] = wdat;
        IDX_ADDR_HI: coreNext.addr[15:8] = wdat;
        IDX_DATA:    coreNext.pdata = wdat;
        IDX_STATUS: begin
          if (wdat[STAT_ERROR_BIT]) begin
            coreNext.error = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Error setting follows the clear above, so a refusal is never lost.
    case (coreReg.state)
      ST_IDLE: begin
        if (cmdWr) begin
          if (refuse) begin
            coreNext.error = 1'b1;
          end else if (op == CMD_PROGRAM) begin
            coreNext.state = ST_PROGRAM;
            coreNext.cur   = addrIdx;
          end else begin
            coreNext.state = ST_ERASE;
            if (op == CMD_ERASE_ALL) begin
              coreNext.first = '0;
              coreNext.last  = LAST_IDX;
            end else if (hitS0 || hitS1) begin
              coreNext.first = addrIdx & ~SEC_MASK;
              coreNext.last  = addrIdx | SEC_MASK;
            end else begin
              coreNext.first = '0;
              coreNext.last  = SEC2_LAST_IDX;
            end
            coreNext.cur = coreNext.first;
          end
        end else if (optClear) begin
          coreNext.state      = ST_ERASE;
          coreNext.first      = '0;
          coreNext.last       = LAST_IDX;
          coreNext.cur        = '0;
          coreNext.unlockPend = 1'b1;
        end else if (optSet) begin
          coreNext.lock = 1'b1;
        end
      end
      ST_PROGRAM: begin
        coreNext.state = ST_IDLE;
      end
      ST_ERASE: begin
        if (coreReg.cur == coreReg.last) begin
          coreNext.state = ST_IDLE;
          if (coreReg.unlockPend) begin
            coreNext.lock       = 1'b0;
            coreNext.unlockPend = 1'b0;
          end
        end else begin
          coreNext.cur = coreReg.cur + AW'(1);
        end
      end
      default: begin
        coreNext.state = ST_IDLE;
      end
    endcase

    // Commands while busy are refused rather than queued.
    if ((cmdWr || optWr) && (coreReg.state != ST_IDLE)) begin
      coreNext.error = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      coreReg <= CORE_RESET;
    end else begin
      coreReg <= coreNext;
    end
  end

  // Link side: the clock stands still while detached, so detach is the reset.
  always_comb begin
    linkNext      = linkReg;
    linkNext.att1 = toolAttached;
    linkNext.att2 = linkReg.att1;
    linkNext.ack1 = coreReg.in_circuit_link;
    linkNext.ack2 = linkReg.ack1;
    if (!linkReg.att2) begin
      linkNext.bitCnt   = LINK_IDLE.bitCnt;
      linkNext.shift    = LINK_IDLE.shift;
      linkNext.enterTgl = LINK_IDLE.enterTgl;
      linkNext.drive    = LINK_IDLE.drive;
      linkNext.dout     = LINK_IDLE.dout;
    end else if (linkReg.bitCnt == LINK_RESP_BIT) begin
      linkNext.bitCnt = 4'h0;
      linkNext.drive  = 1'b0;
    end else begin
      linkNext.shift  = {linkReg.shift[6:0], linkDataIn};
      linkNext.bitCnt = linkReg.bitCnt + 4'h1;
      if (linkReg.bitCnt == LINK_LAST_BIT) begin
        linkNext.drive = 1'b1;
        linkNext.dout  = linkReg.ack2;
        if (linkNext.shift == LINK_ENTER_CODE) begin
          linkNext.enterTgl = ~linkReg.enterTgl;
        end
      end
    end
  end

  always_ff @(posedge linkClk) begin
    linkReg <= linkNext;
  end

  fsp_array_mem #(
    .AW (AW),
    .DW (8)
  ) u_array (
    .clk   (clk),
    .we    (memWe),
    .addr  (memAddr),
    .wdata (memWdata),
    .rdata (memRdata)
  );

  // While attached the application loses both directions of the data pin.
  assign linkDataOut   = coreReg.att2 ? linkReg.dout : appDataOut;
  assign linkDataOe    = coreReg.att2 ? linkReg.drive : appDataOe;
  assign appDataIn     = coreReg.att2 ? 1'b0 : coreReg.pin2;
  assign wbRsp.ack     = coreReg.ack;
  assign wbRsp.dat     = {24'h000000, coreReg.rdat};
  assign progMode      = coreReg.mode;
  assign readoutLocked = coreReg.lock;

  sequence s_unlock_req;
    (coreReg.state == ST_IDLE) && optClear;
  endsequence

  sequence s_unlock_run;
    (coreReg.state == ST_ERASE) && coreReg.unlockPend;
  endsequence

  a_unlock_erase: assert property (@(posedge clk) disable iff (srst)
    s_unlock_req |=> s_unlock_run ##0 (coreReg.cur == '0) ##0 coreReg.lock)
    else $error("Lock removal did not start a full erase.");

  a_unlock_done: assert property (@(posedge clk) disable iff (srst)
    s_unlock_run ##0 (coreReg.cur == LAST_IDX) |=> !coreReg.lock && (coreReg.state == ST_IDLE))
    else $error("Lock not cleared after full erase.");

  a_erase_bounds: assert property (@(posedge clk) disable iff (srst)
    (coreReg.state == ST_ERASE) |-> (coreReg.cur >= coreReg.first) && (coreReg.cur <= coreReg.last))
    else $error("Erase address left its sector.");

  a_sector0_guard: assert property (@(posedge clk) disable iff (srst)
    (coreReg.state == ST_IDLE) && cmdWr && (coreReg.mode == MODE_APP) && hitS0
    |=> (coreReg.state == ST_IDLE) && coreReg.error && !memWe)
    else $error("Sector 0 touched in self-programming mode.");

  a_lock_no_write: assert property (@(posedge clk) disable iff (srst)
    coreReg.lock && !coreReg.unlockPend |-> !memWe)
    else $error("Array written while readout lock is set.");

  a_refuse_flag: assert property (@(posedge clk) disable iff (srst)
    (coreReg.state == ST_IDLE) && cmdWr && refuse |=> coreReg.error && !memWe)
    else $error("Forbidden command was not refused.");

  a_program_byte: assert property (@(posedge clk) disable iff (srst)
    (coreReg.state == ST_IDLE) && cmdWr && !refuse && (op == CMD_PROGRAM)
    |=> memWe && (memAddr == $past(addrIdx)) ##1 (coreReg.state == ST_IDLE) && !memWe)
    else $error("Byte program did not write exactly one byte.");

  a_fpc_reset: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> (coreReg.fpc == FPC_RESET) && (wbRsp.ack == 1'b0))
    else $error("Control byte not at reset value after reset.");

  a_enter_icc: assert property (@(posedge clk) disable iff (srst)
    coreReg.att2 && !coreReg.sock2 && enterEdge |=> (progMode == MODE_ICC) ##1 coreReg.in_circuit_link)
    else $error("Link request did not enter in-circuit mode.");

  a_pins_owned: assert property (@(posedge clk) disable iff (srst)
    coreReg.att2 |-> (linkDataOe == linkReg.drive) && !appDataIn)
    else $error("Application still owns the link pin.");

  a_link_drive_one: assert property (@(posedge linkClk) disable iff (!linkReg.att2)
    linkReg.drive |=> !linkReg.drive)
    else $error("Response bit driven for more than one link clock.");

endmodule // fsp_flash_access

/* File: hw/fsp_pkg.sv */
package fsp_pkg;

  localparam int unsigned WB_ADR_W = 10;
  localparam int unsigned WB_DAT_W = 32;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_FPC     = 8'h37;
  localparam logic [7:0] IDX_ADDR_LO = 8'h40;
  localparam logic [7:0] IDX_ADDR_HI = 8'h41;
  localparam logic [7:0] IDX_DATA    = 8'h42;
  localparam logic [7:0] IDX_CMD     = 8'h43;
  localparam logic [7:0] IDX_STATUS  = 8'h44;
  localparam logic [7:0] IDX_OPTION  = 8'h45;

  localparam logic [7:0]  FPC_RESET     = 8'h00;
  localparam int unsigned FPC_ARM_BIT   = 0;
  localparam int unsigned STAT_ERROR_BIT = 1;
  localparam int unsigned OPT_LOCK_BIT  = 0;

  localparam int unsigned SECTOR_BYTES = 4096;
  localparam int unsigned SECTOR_AW    = 12;
  localparam logic [3:0]  SECTOR0_TOP  = 4'hF;
  localparam logic [3:0]  SECTOR1_TOP  = 4'hE;
  localparam logic [15:0] SECTOR2_LAST = 16'hDFFF;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;

  localparam logic [7:0] LINK_ENTER_CODE = 8'hA5;
  localparam logic [3:0] LINK_LAST_BIT   = 4'h7;
  localparam logic [3:0] LINK_RESP_BIT   = 4'h8;

  typedef enum logic [1:0] {
    CMD_NONE         = 2'b00,
    CMD_PROGRAM      = 2'b01,
    CMD_ERASE_SECTOR = 2'b10,
    CMD_ERASE_ALL    = 2'b11
  } fsp_cmd_type;

  typedef enum logic [1:0] {
    MODE_APP    = 2'b00,
    MODE_ICC    = 2'b01,
    MODE_SOCKET = 2'b10
  } fsp_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_PROGRAM = 2'b01,
    ST_ERASE   = 2'b10
  } fsp_state_type;

  typedef struct packed {
    logic                cyc;
    logic                stb;
    logic                we;
    logic [WB_ADR_W-1:0] adr;
    logic [3:0]          sel;
    logic [WB_DAT_W-1:0] dat;
  } fsp_wb_req_type;

  typedef struct packed {
    logic                ack;
    logic [WB_DAT_W-1:0] dat;
  } fsp_wb_rsp_type;

  typedef struct packed {
    logic       att1;
    logic       att2;
    logic       ack1;
    logic       ack2;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic       enterTgl;
    logic       drive;
    logic       dout;
  } fsp_link_type;

endpackage

/* File: verif/flash_sector_protection_access_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin numErrors++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module flash_sector_protection_access_bench;
  import fsp_pkg::*;
  localparam int LIMIT = 80000;
  logic           clk = 1'b0;
  logic           srst = 1'b1;
  logic           socketMode = 1'b0;
  logic           appDataOut = 1'b1;
  logic           appDataOe = 1'b1;
  fsp_wb_req_type wbReq = '0;
  fsp_wb_rsp_type wbRsp;
  fsp_mode_type   progMode;
  logic           linkClk, toolAttached, toolOe, toolOut, pin;
  logic           linkDataOut, linkDataOe, appDataIn, readoutLocked, r;
  logic [7:0]     q;
  int             numErrors = 0;
  int             compares = 0;
  int             cycles = 0;

  always #2.5 clk = ~clk;

  // Nobody driving leaves the line at the board pull-up level.
  assign pin = linkDataOe ? linkDataOut : (toolOe ? toolOut : 1'b1);

  fsp_flash_access #(.ARRAY_BYTES(8192), .LOCK_DEFAULT(1'b0)) dut_u (
    .clk(clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp), .linkClk(linkClk),
    .linkDataIn(pin), .linkDataOut(linkDataOut), .linkDataOe(linkDataOe),
    .toolAttached(toolAttached), .socketMode(socketMode), .appDataOut(appDataOut),
    .appDataOe(appDataOe), .appDataIn(appDataIn), .progMode(progMode),
    .readoutLocked(readoutLocked)
  );

  fsp_tool_model tool (
    .linkClk(linkClk), .toolAttached(toolAttached), .toolOe(toolOe),
    .toolOut(toolOut), .pinLevel(pin)
  );

  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      numErrors++;
      wrapUp();
    end
  end

  // The request stands until ack is seen high at a rising edge; read data are taken there.
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                     output logic [7:0] rd);
    @(posedge clk);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'hF, dat: {24'h0, d}};
    do begin
      @(posedge clk);
    end while (wbRsp.ack !== 1'b1);
    rd = wbRsp.dat[7:0];
    wbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] tmp;
    bus(idx, 1'b1, d, tmp);
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(idx, 1'b0, 8'h00, q);
  endtask

  task automatic waitIdle();
    do begin
      rd(IDX_STATUS);
    end while (q[0] !== 1'b0);
  endtask

  task automatic cmd(input logic [15:0] a, input fsp_cmd_type c, input logic [7:0] d);
    wr(IDX_DATA, d);
    wr(IDX_ADDR_LO, a[7:0]);
    wr(IDX_ADDR_HI, a[15:8]);
    wr(IDX_CMD, {6'h00, c});
    waitIdle();
  endtask

  task automatic peek(input logic [15:0] a, input logic [7:0] e);
    wr(IDX_ADDR_LO, a[7:0]);
    wr(IDX_ADDR_HI, a[15:8]);
    rd(IDX_DATA);
    `CHK(q, e)
  endtask

  // The error flag is sticky, so it is cleared after every look.
  task automatic errIs(input logic e);
    rd(IDX_STATUS);
    `CHK(q[STAT_ERROR_BIT], e)
    wr(IDX_STATUS, 8'h02);
  endtask

  task automatic tRegs();
    rd(IDX_FPC);
    `CHK(q, FPC_RESET)
    wr(IDX_FPC, 8'hA5);
    rd(IDX_FPC);
    `CHK(q, 8'hA5)
    rd(8'h3F);
    `CHK(q, 8'h00)
    wr(IDX_FPC, 8'h01);
  endtask

  // The bench plays the loader already resident in sector 0.
  task automatic tApp();
    `CHK(progMode, MODE_APP)
    cmd(16'hE000, CMD_ERASE_SECTOR, 8'h00);
    errIs(1'b0);
    peek(16'hEFFF, ERASED_BYTE);
    cmd(16'hE010, CMD_PROGRAM, 8'h3C);
    peek(16'hE010, 8'h3C);
    cmd(16'hF000, CMD_PROGRAM, 8'h00);
    errIs(1'b1);
    cmd(16'h0000, CMD_ERASE_ALL, 8'h00);
    errIs(1'b1);
    cmd(16'hD000, CMD_PROGRAM, 8'h00);
    errIs(1'b1);
    peek(16'hE010, 8'h3C);
  endtask

  // Reset stays released for the whole session.
  task automatic tLink();
    `CHK(linkDataOe, 1'b1)
    `CHK(appDataIn, 1'b1)
    appDataOut <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(linkDataOut, 1'b0)
    `CHK(appDataIn, 1'b0)
    tool.attach(1'b1);
    `CHK(linkDataOe, 1'b0)
    `CHK(appDataIn, 1'b0)
    `CHK(pin, 1'b1)
    tool.sendFrame(8'h5A, r);
    `CHK(r, 1'b0)
    repeat (8) @(posedge clk);
    `CHK(progMode, MODE_APP)
    tool.enterLink(r);
    `CHK(r, 1'b0)
    repeat (8) @(posedge clk);
    `CHK(progMode, MODE_ICC)
    tool.sendFrame(8'h00, r);
    `CHK(r, 1'b1)
  endtask

  task automatic tIcc();
    cmd(16'h0000, CMD_ERASE_ALL, 8'h00);
    errIs(1'b0);
    peek(16'hE010, ERASED_BYTE);
    cmd(16'hFFFE, CMD_PROGRAM, 8'h12);
    peek(16'hFFFE, 8'h12);
    cmd(16'hE020, CMD_PROGRAM, 8'h34);
    cmd(16'hF800, CMD_ERASE_SECTOR, 8'h00);
    peek(16'hFFFE, ERASED_BYTE);
    peek(16'hE020, 8'h34);
  endtask

  task automatic tLock();
    wr(IDX_OPTION, 8'h01);
    `CHK(readoutLocked, 1'b1)
    peek(16'hE020, 8'h00);
    cmd(16'hE030, CMD_PROGRAM, 8'h00);
    errIs(1'b1);
    wr(IDX_OPTION, 8'h00);
    waitIdle();
    `CHK(readoutLocked, 1'b0)
    peek(16'hE020, ERASED_BYTE);
  endtask

  task automatic tArm();
    wr(IDX_FPC, 8'h00);
    cmd(16'hE040, CMD_PROGRAM, 8'h00);
    errIs(1'b1);
    peek(16'hE040, ERASED_BYTE);
    wr(IDX_FPC, 8'h01);
    cmd(16'hE040, CMD_NONE, 8'h00);
    errIs(1'b1);
    wr(IDX_CMD, {6'h00, CMD_ERASE_SECTOR});
    wr(IDX_CMD, {6'h00, CMD_PROGRAM});
    waitIdle();
    errIs(1'b1);
  endtask

  task automatic tSocket();
    tool.attach(1'b0);
    @(posedge clk);
    socketMode <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(progMode, MODE_SOCKET)
    cmd(16'hF001, CMD_PROGRAM, 8'h55);
    errIs(1'b0);
    peek(16'hF001, 8'h55);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    tool.attach(1'b0);
    tRegs();
    tApp();
    tLink();
    tIcc();
    tLock();
    tArm();
    tSocket();
    wrapUp();
  end
endmodule // flash_sector_protection_access_bench

/* File: verif/fsp_tool_model.sv */
`timescale 1ns/1ps
module fsp_tool_model (
  output logic      linkClk,
  output logic      toolAttached,
  output logic      toolOe,
  output logic      toolOut,
  input  wire logic pinLevel
);
  import fsp_pkg::*;
  localparam int HALF = 32;

  initial begin
    linkClk = 1'b0;
    toolAttached = 1'b0;
    toolOe = 1'b0;
    toolOut = 1'b0;
  end

  // The clock only moves inside these tasks, so it stands still between frames.
  task automatic tick();
    #HALF linkClk = 1'b1;
    #HALF linkClk = 1'b0;
  endtask

  // The link counts bits from the third edge after attach, so two edges lead a frame.
  task automatic attach(input logic on);
    toolAttached = on;
    repeat (on ? 2 : 4) tick();
  endtask

  // The line is let go just after the eighth edge so the device can answer on it.
  task automatic sendFrame(input logic [7:0] code, output logic resp);
    for (int i = 7; i >= 0; i--) begin
      toolOe = 1'b1;
      toolOut = code[i];
      #HALF linkClk = 1'b1;
      #1 toolOe = (i != 0);
      #(HALF-1) linkClk = 1'b0;
    end
    resp = pinLevel;
    tick();
  endtask

  task automatic enterLink(output logic resp);
    sendFrame(LINK_ENTER_CODE, resp);
  endtask
endmodule // fsp_tool_model
